/* common/ucac_regs.svh */
`ifndef UCAC_REGS_SVH
`define UCAC_REGS_SVH
// Timebase: one slow tick per millisecond at 250 MHz.
`define UCAC_CLK_KHZ          250000
`define UCAC_TICK_MS          1
`define UCAC_TICK_CYC         (`UCAC_CLK_KHZ * `UCAC_TICK_MS)
// Timer lengths in milliseconds, counted in slow ticks.
`define UCAC_DISCH_MS         350
`define UCAC_ATTACH_HOLD_MS   25000
`define UCAC_OC_DEGLITCH_MS   9
`define UCAC_SAFETY_MS        10800000
`define UCAC_DCP_RETURN_MS    10000
`define UCAC_OT_RELEASE_MS    9
// Mode-select codes.
`define UCAC_MODE_OFF         3'h0
`define UCAC_MODE_DCP_AUTO    3'h1
`define UCAC_MODE_SDP_WAKE    3'h2
`define UCAC_MODE_CDP_WAKE    3'h3
`define UCAC_MODE_DCP_FORCED  3'h4
`define UCAC_MODE_DIVIDER     3'h5
`define UCAC_MODE_SDP         3'h6
`define UCAC_MODE_CDP         3'h7
`endif

/* common/ucac_pkg.sv */
package ucac_pkg;
  // Attach detector states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    ATT_IDLE   = 2'b00,
    ATT_ARMED  = 2'b01,
    ATT_REMOVE = 2'b11
  } ucac_att_t;
endpackage

/* design/ucac_ctrl.sv */
// Operation
// - Any defined mode change with enable high drives a 350 ms output discharge pulse.
// - Changes between x10 or 111 and 011 skip the discharge pulse.
// - Permanent discharge when both enables low, or enable high, attach low, code 000.
// - Attach detector on only with attach-enable high, enable low.
// - Loads present on entering attach mode are ignored until removed.
// - Detected attachment asserts the charge flag for a 25 s hold.
// - Charging during the hold keeps the flag; otherwise released at hold end.
// - In CDP or DCP modes, current above 20 mA asserts the flag.
// - In CDP mode the flag needs the handshake done before the current rose.
// - A flag already set by attach is left unchanged by charging detection.
// - Safety timer starts only after an attach seen with attach-enable high.
// - Timer stops and flag releases on current below threshold or 3 hours.
// - Attach-enable falling stops the timer, keeps the flag, no time limit.
// - Charging without a preceding attach never starts the safety timer.
// - Back in attach mode, wait for removal, then detect the next attach.
// - Fault output asserts during overcurrent or overtemperature until it clears.
// - Overcurrent is reported only after persisting 9 ms.
// - Overtemperature reports at once; release waits a delay after switch restarts.
// - Switch off at overtemperature, back on only after the hysteresis signal.
// - Enable low turns off switches and profiles and clears the fault flag, but not the charge flag during an attach hold.
// - Enable low with attach-enable high enters attach detection mode.
// - Mode-select codes decode to off, SDP, CDP, wakeup, DCP and divider modes.
// - DCP auto mode returns to divider 10 s after a BC1.2 load leaves.
`timescale 1ns/10ps
`default_nettype none
`include "ucac_regs.svh"

module ucac_ctrl #(
  parameter int unsigned TICK_CYC   = `UCAC_TICK_CYC,
  parameter int unsigned DISCH_T    = `UCAC_DISCH_MS / `UCAC_TICK_MS,
  parameter int unsigned HOLD_T     = `UCAC_ATTACH_HOLD_MS / `UCAC_TICK_MS,
  parameter int unsigned OC_T       = `UCAC_OC_DEGLITCH_MS / `UCAC_TICK_MS,
  parameter int unsigned SAFETY_T   = `UCAC_SAFETY_MS / `UCAC_TICK_MS,
  parameter int unsigned DCP_RET_T  = `UCAC_DCP_RETURN_MS / `UCAC_TICK_MS,
  parameter int unsigned OT_REL_T   = `UCAC_OT_RELEASE_MS / `UCAC_TICK_MS
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Host control pins.
  input  wire logic       enable,
  input  wire logic       attach_enable,
  input  wire logic [2:0] mode_select_pins,
  // Analog sense indications.
  input  wire logic       attach_sensed,
  input  wire logic       load_present,
  input  wire logic       chg_current_above,
  input  wire logic       cdp_handshake_done,
  input  wire logic       bc12_load_present,
  input  wire logic       overcurrent,
  input  wire logic       overtemp,
  input  wire logic       overtemp_cooled,
  // Power and emulation controls.
  output logic            power_switch_on,
  output logic            data_switch_on,
  output logic            profiles_on,
  output logic            discharge_on,
  output logic            attach_detector_on,
  output logic            dcp_divider_sel,
  // Open-drain flags, enable high while pulling low.
  output logic            chg_attach_n_o,
  output logic            chg_attach_n_oe,
  output logic            fault_n_o,
  output logic            fault_n_oe
);

  // -------------------------------------------------------------------
  // Timebase and mode decode
  // -------------------------------------------------------------------

  logic [31:0] div_r;
  logic        tick_r;
  logic [2:0]  mode_r;
  logic        mode_vld_r;
  logic        att_mode;
  logic        chg_mode;
  logic        cdp_mode;
  logic        wake_pair;

  // Common slow tick for every timer.
  // common slow tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end
    else if (div_r >= TICK_CYC - 1)
    begin
      div_r  <= 32'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  assign att_mode = attach_enable && !enable;
  assign cdp_mode = (mode_select_pins == `UCAC_MODE_CDP) ||
                    (mode_select_pins == `UCAC_MODE_CDP_WAKE);
  assign chg_mode = enable && (cdp_mode ||
                    (mode_select_pins == `UCAC_MODE_DCP_AUTO) ||
                    (mode_select_pins == `UCAC_MODE_DCP_FORCED) ||
                    (mode_select_pins == `UCAC_MODE_DIVIDER));
  assign wake_pair =
    ((mode_r[1:0] == 2'h2 || mode_r == `UCAC_MODE_CDP) &&
     mode_select_pins == `UCAC_MODE_CDP_WAKE) ||
    (mode_r == `UCAC_MODE_CDP_WAKE &&
     (mode_select_pins[1:0] == 2'h2 || mode_select_pins == `UCAC_MODE_CDP));

  // -------------------------------------------------------------------
  // Discharge pulse and permanent discharge
  // -------------------------------------------------------------------

  logic [31:0] disch_cnt_r;
  logic        pulse_r;
  logic        perm_disch;

  assign perm_disch = !attach_enable &&
                      (!enable || mode_select_pins == `UCAC_MODE_OFF);

  // Track the mode and time the discharge pulse after each change with enable high, wake pairs excepted.
  // mode change pulse
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r      <= `UCAC_MODE_OFF;
      mode_vld_r  <= 1'b0;
      disch_cnt_r <= 32'h0;
      pulse_r     <= 1'b0;
    end
    else
    begin
      mode_r     <= mode_select_pins;
      mode_vld_r <= 1'b1;
      if (mode_vld_r && enable && mode_select_pins != mode_r && !wake_pair)
      begin
        pulse_r     <= 1'b1;
        disch_cnt_r <= 32'h0;
      end
      else if (pulse_r && tick_r)
      begin
        if (disch_cnt_r >= DISCH_T - 1)
          pulse_r <= 1'b0;
        disch_cnt_r <= disch_cnt_r + 32'h1;
      end
    end
  end

  // -------------------------------------------------------------------
  // Attach detector
  // -------------------------------------------------------------------

  ucac_pkg::ucac_att_t att_st_r;
  logic                att_evt;

  assign att_evt = (att_st_r == ucac_pkg::ATT_ARMED) && att_mode && attach_sensed;

  // On entry, a present load must leave before detection is armed.
  // ignore present loads
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      att_st_r <= ucac_pkg::ATT_IDLE;
    else
    begin
      case (att_st_r)
        ucac_pkg::ATT_IDLE:
          if (att_mode)
            att_st_r <= load_present ? ucac_pkg::ATT_REMOVE : ucac_pkg::ATT_ARMED;
        ucac_pkg::ATT_ARMED:
          if (!att_mode || attach_sensed)
            att_st_r <= ucac_pkg::ATT_IDLE;
        ucac_pkg::ATT_REMOVE:
          if (!att_mode)
            att_st_r <= ucac_pkg::ATT_IDLE;
          else if (!load_present)
            att_st_r <= ucac_pkg::ATT_ARMED;
        default:
          att_st_r <= ucac_pkg::ATT_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Attach hold, charging flag and safety timer
  // -------------------------------------------------------------------

  logic [31:0] hold_cnt_r;
  logic        hold_r;
  logic        chg_r;
  logic        cdp_ok_r;
  logic        safety_run_r;
  logic        safety_arm_r;
  logic [31:0] safety_cnt_r;
  logic        chg_ok;

  assign chg_ok = chg_mode && chg_current_above && (!cdp_mode || cdp_ok_r);

  // CDP qualifier: handshake must precede the current rising.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cdp_ok_r <= 1'b0;
    else if (!cdp_mode || !enable)
      cdp_ok_r <= 1'b0;
    else if (cdp_handshake_done && !chg_current_above)
      cdp_ok_r <= 1'b1;
  end

  // Attach hold window; restarts on a fresh attach.
  // attach hold
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_r     <= 1'b0;
      hold_cnt_r <= 32'h0;
    end
    else if (att_evt)
    begin
      hold_r     <= 1'b1;
      hold_cnt_r <= 32'h0;
    end
    else if (hold_r && tick_r)
    begin
      if (hold_cnt_r >= HOLD_T - 1)
        hold_r <= 1'b0;
      hold_cnt_r <= hold_cnt_r + 32'h1;
    end
  end

  // Charging condition, with the safety timer gating it off.
  // current threshold flag
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      chg_r <= 1'b0;
    else if (!chg_ok)
      chg_r <= 1'b0;
    else if (safety_run_r && tick_r && safety_cnt_r >= SAFETY_T - 1)
      chg_r <= 1'b0;
    else if (!safety_run_r && safety_arm_r && safety_cnt_r != 32'h0)
      chg_r <= chg_r;
    else
      chg_r <= 1'b1;
  end

  // Safety timer, armed only by an attach event.
  // attach starts timer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      safety_arm_r <= 1'b0;
      safety_run_r <= 1'b0;
      safety_cnt_r <= 32'h0;
    end
    else if (att_evt && attach_enable)
    begin
      safety_arm_r <= 1'b1;
      safety_run_r <= 1'b0;
      safety_cnt_r <= 32'h0;
    end
    else if (!attach_enable)
    begin
      safety_arm_r <= 1'b0;
      safety_run_r <= 1'b0;
      safety_cnt_r <= 32'h0;
    end
    else if (safety_arm_r && !safety_run_r && safety_cnt_r == 32'h0 && chg_ok)
      safety_run_r <= 1'b1;
    else if (safety_run_r && !chg_ok)
    begin
      safety_run_r <= 1'b0;
      safety_arm_r <= 1'b0;
    end
    else if (safety_run_r && tick_r)
    begin
      // Expiry keeps the arm bit, so the flag stays released while current flows.
      if (safety_cnt_r >= SAFETY_T - 1)
        safety_run_r <= 1'b0;
      safety_cnt_r <= safety_cnt_r + 32'h1;
    end
    // An expired timer is forgotten once the charging current drops.
    else if (safety_arm_r && !safety_run_r && safety_cnt_r != 32'h0 && !chg_ok)
      safety_arm_r <= 1'b0;
  end

  // -------------------------------------------------------------------
  // Fault reporting and thermal switch control
  // -------------------------------------------------------------------

  logic [31:0] oc_cnt_r;
  logic        oc_rep_r;
  logic        ot_off_r;
  logic        ot_rep_r;
  logic [31:0] ot_cnt_r;

  // Overcurrent deglitch.
  // overcurrent deglitch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oc_cnt_r <= 32'h0;
      oc_rep_r <= 1'b0;
    end
    else if (!overcurrent || !enable)
    begin
      oc_cnt_r <= 32'h0;
      oc_rep_r <= 1'b0;
    end
    else if (tick_r && !oc_rep_r)
    begin
      if (oc_cnt_r >= OC_T - 1)
        oc_rep_r <= 1'b1;
      oc_cnt_r <= oc_cnt_r + 32'h1;
    end
  end

  // Thermal shutdown with hysteresis and delayed flag release.
  // thermal hysteresis
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ot_off_r <= 1'b0;
      ot_rep_r <= 1'b0;
      ot_cnt_r <= 32'h0;
    end
    else if (overtemp)
    begin
      ot_off_r <= 1'b1;
      ot_rep_r <= enable;
      ot_cnt_r <= 32'h0;
    end
    else if (ot_off_r)
    begin
      if (overtemp_cooled)
        ot_off_r <= 1'b0;
      ot_rep_r <= ot_rep_r && enable;
    end
    else if (ot_rep_r && tick_r)
    begin
      if (ot_cnt_r >= OT_REL_T - 1 || !enable)
        ot_rep_r <= 1'b0;
      ot_cnt_r <= ot_cnt_r + 32'h1;
    end
  end

  // -------------------------------------------------------------------
  // DCP auto divider return
  // -------------------------------------------------------------------

  logic [31:0] ret_cnt_r;
  logic        bc12_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bc12_r    <= 1'b0;
      ret_cnt_r <= 32'h0;
    end
    else if (!enable || mode_select_pins != `UCAC_MODE_DCP_AUTO)
    begin
      bc12_r    <= 1'b0;
      ret_cnt_r <= 32'h0;
    end
    else if (bc12_load_present)
    begin
      bc12_r    <= 1'b1;
      ret_cnt_r <= 32'h0;
    end
    else if (bc12_r && tick_r)
    begin
      if (ret_cnt_r >= DCP_RET_T - 1)
        bc12_r <= 1'b0;
      ret_cnt_r <= ret_cnt_r + 32'h1;
    end
  end

  // -------------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------------

  // Drive every output from flops; enable low clears the fault flag, and the attach hold can still set the charge flag.
  // disable clears switches, profiles and fault flag
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_switch_on    <= 1'b0;
      data_switch_on     <= 1'b0;
      profiles_on        <= 1'b0;
      discharge_on       <= 1'b0;
      attach_detector_on <= 1'b0;
      dcp_divider_sel    <= 1'b0;
      chg_attach_n_oe    <= 1'b0;
      fault_n_oe         <= 1'b0;
    end
    else
    begin
      power_switch_on    <= enable && !ot_off_r && !pulse_r &&
                            mode_select_pins != `UCAC_MODE_OFF;
      data_switch_on     <= enable && mode_select_pins[1];
      profiles_on        <= enable && mode_select_pins != `UCAC_MODE_OFF;
      discharge_on       <= perm_disch || (enable && pulse_r);
      attach_detector_on <= att_mode;
      dcp_divider_sel    <= enable && !bc12_r &&
                            (mode_select_pins == `UCAC_MODE_DCP_AUTO ||
                             mode_select_pins == `UCAC_MODE_DIVIDER);
      chg_attach_n_oe    <= (hold_r || (enable && chg_r));
      fault_n_oe         <= enable && (oc_rep_r || ot_rep_r);
    end
  end

  // Open-drain data lines always pull low when enabled.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chg_attach_n_o <= 1'b0;
      fault_n_o      <= 1'b0;
    end
    else
    begin
      chg_attach_n_o <= 1'b0;
      fault_n_o      <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------

  sequence s_ot_rise;
    $rose(overtemp);
  endsequence

  a_perm_discharge: assert property (@(posedge clk) disable iff (!arst_n)
    perm_disch |=> discharge_on)
    else $error("permanent discharge missing");

  a_detector_gate: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 (attach_detector_on == $past(att_mode)))
    else $error("attach detector gating wrong");

  a_hold_flag: assert property (@(posedge clk) disable iff (!arst_n)
    att_evt |=> ##1 chg_attach_n_oe)
    else $error("attach flag not asserted");

  a_ot_immediate: assert property (@(posedge clk) disable iff (!arst_n)
    (s_ot_rise ##0 enable) |=> ##1 fault_n_oe)
    else $error("overtemp fault late");

  a_ot_switch_off: assert property (@(posedge clk) disable iff (!arst_n)
    overtemp |=> ##1 !power_switch_on)
    else $error("switch on during overtemp");

  a_disable_clears: assert property (@(posedge clk) disable iff (!arst_n)
    (!enable [*2]) |=> (!fault_n_oe && !power_switch_on && !data_switch_on))
    else $error("disable did not clear outputs");

  a_oc_glitch: assert property (@(posedge clk) disable iff (!arst_n)
    (!overcurrent && !overtemp && !ot_rep_r) |=> ##1 !fault_n_oe)
    else $error("fault without cause");

  a_no_attach_timer: assert property (@(posedge clk) disable iff (!arst_n)
    (!safety_arm_r && !att_evt) |=> !safety_run_r)
    else $error("safety timer without attach");

  a_pulse_start: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_vld_r && enable && mode_select_pins != mode_r && !wake_pair) |=> ##1 discharge_on)
    else $error("discharge pulse missing");

endmodule
`default_nettype wire

/* tb/ucac_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host controller model
// ----------------------------------------
module ucac_host_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Requests from the bench.
  input  wire logic en_req,
  input  wire logic auto_off,
  // Open-drain drivers of the block.
  input  wire logic chg_attach_n_oe,
  input  wire logic fault_n_oe,
  // Host side of the pins.
  output logic      enable,
  output logic      chg_attach_n,
  output logic      fault_n
);
  logic off_r;
  // Pull-ups keep each flag high unless the block pulls it low.
  assign chg_attach_n = chg_attach_n_oe ? 1'h0 : 1'h1;
  assign fault_n      = fault_n_oe ? 1'h0 : 1'h1;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      off_r <= 1'h0;
    else if (!en_req)
      off_r <= 1'h0;
    else if (auto_off && !fault_n)
      off_r <= 1'h1;
  end
  // Enable stays low after a fault seen with auto_off high, until the bench drops en_req.
  assign enable = en_req & ~off_r;
endmodule
`default_nettype wire

/* tb/ucac_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ucac_ctrl_tb;
  // ----------------------------------------
  // Shortened timers and signals
  // ----------------------------------------
  localparam int TK = 4;
  localparam int HT = 5;
  logic       clk, arst_n, en_req, auto_off, attach_enable, attach_sensed;
  logic       load_present, chg_current_above, cdp_handshake_done, bc12_load_present;
  logic       overcurrent, overtemp, overtemp_cooled, enable, chg_attach_n, fault_n;
  logic [2:0] mode_select_pins;
  logic       power_switch_on, data_switch_on, profiles_on, discharge_on;
  logic       attach_detector_on, dcp_divider_sel;
  logic       chg_attach_n_o, chg_attach_n_oe, fault_n_o, fault_n_oe;
  int         err_count, checks, n;

  ucac_ctrl #(.TICK_CYC(TK), .DISCH_T(3), .HOLD_T(HT), .OC_T(2), .SAFETY_T(8),
    .DCP_RET_T(4), .OT_REL_T(2)) ucac_ctrl_i (.clk, .arst_n, .enable, .attach_enable,
    .mode_select_pins, .attach_sensed, .load_present, .chg_current_above,
    .cdp_handshake_done, .bc12_load_present, .overcurrent, .overtemp, .overtemp_cooled,
    .power_switch_on, .data_switch_on, .profiles_on, .discharge_on, .attach_detector_on,
    .dcp_divider_sel, .chg_attach_n_o, .chg_attach_n_oe, .fault_n_o, .fault_n_oe);
  ucac_host_model ucac_host_model_i (.clk, .arst_n, .en_req, .auto_off,
    .chg_attach_n_oe, .fault_n_oe, .enable, .chg_attach_n, .fault_n);

  // The clock toggles every 2 ns, half of its 4 ns period.
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Selects one observed level: pulse, charge flag, fault flag, switch, divider.
  function logic sig(input int s);
    case (s)
      0: return discharge_on;
      1: return ~chg_attach_n;
      2: return ~fault_n;
      3: return power_switch_on;
      default: return dcp_divider_sel;
    endcase
  endfunction

  // Waits a bounded number of cycles for a level.
  task wt(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask

  // Arms the detector with no load, then plugs a load in.
  task attach_ev;
    load_present = 1'h0;
    attach_sensed = 1'h0;
    cyc(3);
    attach_sensed = 1'h1;
    load_present = 1'h1;
    wt(1, 1'h1, 5);
    chk("attach_flag", sig(1), 1'h1);
    attach_sensed = 1'h0;
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_enables;
    logic [1:0] cmb [4];
    logic [2:0] md [4];
    cmb = '{2'h0, 2'h1, 2'h3, 2'h2};
    md = '{3'h6, 3'h6, 3'h6, 3'h0};
    for (int i = 0; i < 4; i++)
    begin
      en_req = cmb[i][1];
      attach_enable = cmb[i][0];
      mode_select_pins = md[i];
      cyc(30);
      chk("discharge", discharge_on, 4'h9 >> i & 1);
      chk("detector", attach_detector_on, i == 1);
      if (!cmb[i][1])
        chk("off", {power_switch_on, data_switch_on, profiles_on}, 8'h00);
      else if (md[i] != 3'h0)
        chk("on", {power_switch_on, data_switch_on, profiles_on}, 8'h07);
    end
    attach_enable = 1'h1;
    mode_select_pins = 3'h6;
    cyc(30);
    $display("done enables");
  endtask

  task t_modes;
    logic [2:0] sq [10];
    logic [9:0] pe;
    sq = '{3'h7, 3'h3, 3'h7, 3'h3, 3'h2, 3'h5, 3'h1, 3'h4, 3'h6, 3'h3};
    pe = 10'h1e1;
    for (int i = 0; i < 10; i++)
    begin
      mode_select_pins = sq[i];
      wt(0, 1'h1, 6);
      chk("pulse", sig(0), pe[i]);
      wt(0, 1'h0, 30);
      if (pe[i])
        chk("pulse_len", n >= 8 && n <= 17, 1'h1);
      cyc(6);
      if (sq[i] == 3'h5)
        chk("divider", dcp_divider_sel, 1'h1);
    end
    $display("done modes");
  endtask

  task t_dcp;
    mode_select_pins = 3'h1;
    cyc(30);
    chk("auto_div", dcp_divider_sel, 1'h1);
    bc12_load_present = 1'h1;
    cyc(3);
    chk("bc12_sel", dcp_divider_sel, 1'h0);
    bc12_load_present = 1'h0;
    cyc(10);
    chk("ret_early", dcp_divider_sel, 1'h0);
    wt(4, 1'h1, 16);
    chk("ret_div", dcp_divider_sel, 1'h1);
    $display("done dcp");
  endtask

  task t_charge;
    chg_current_above = 1'h1;
    wt(1, 1'h1, 4);
    chk("dcp_flag", sig(1), 1'h1);
    chg_current_above = 1'h0;
    wt(1, 1'h0, 4);
    chk("dcp_drop", sig(1), 1'h0);
    mode_select_pins = 3'h7;
    cyc(30);
    chg_current_above = 1'h1;
    cyc(10);
    chk("cdp_nohs", sig(1), 1'h0);
    chg_current_above = 1'h0;
    cyc(2);
    cdp_handshake_done = 1'h1;
    cyc(2);
    chg_current_above = 1'h1;
    wt(1, 1'h1, 4);
    chk("cdp_hs", sig(1), 1'h1);
    en_req = 1'h0;
    wt(1, 1'h0, 4);
    chk("dis_flag", sig(1), 1'h0);
    chg_current_above = 1'h0;
    cdp_handshake_done = 1'h0;
    mode_select_pins = 3'h1;
    cyc(5);
    $display("done charge");
  endtask

  task t_attach;
    attach_enable = 1'h0;
    load_present = 1'h1;
    attach_sensed = 1'h1;
    cyc(2);
    attach_enable = 1'h1;
    cyc(10);
    chk("det_on", attach_detector_on, 1'h1);
    chk("pre_load", sig(1), 1'h0);
    attach_ev;
    wt(1, 1'h0, 40);
    chk("hold_len", n >= HT * TK - 4 && n <= HT * TK + 5, 1'h1);
    attach_sensed = 1'h1;
    cyc(10);
    chk("no_removal", sig(1), 1'h0);
    attach_ev;
    wt(1, 1'h0, 40);
    $display("done attach");
  endtask

  task t_safety;
    attach_ev;
    en_req = 1'h1;
    chg_current_above = 1'h1;
    cyc(24);
    chk("hold_chg", sig(1), 1'h1);
    wt(1, 1'h0, 40);
    chk("safety_end", sig(1), 1'h0);
    cyc(8);
    chk("safety_stay", sig(1), 1'h0);
    chg_current_above = 1'h0;
    en_req = 1'h0;
    cyc(5);
    $display("done safety");
  endtask

  task t_nolimit;
    attach_ev;
    en_req = 1'h1;
    chg_current_above = 1'h1;
    cyc(4);
    attach_enable = 1'h0;
    cyc(80);
    chk("no_limit", sig(1), 1'h1);
    chg_current_above = 1'h0;
    wt(1, 1'h0, 4);
    attach_enable = 1'h1;
    cyc(5);
    chg_current_above = 1'h1;
    wt(1, 1'h1, 4);
    cyc(80);
    chk("no_attach", sig(1), 1'h1);
    chg_current_above = 1'h0;
    cyc(5);
    $display("done nolimit");
  endtask

  task t_fault;
    overcurrent = 1'h1;
    cyc(4);
    overcurrent = 1'h0;
    cyc(10);
    chk("oc_glitch", sig(2), 1'h0);
    overcurrent = 1'h1;
    wt(2, 1'h1, 16);
    chk("oc_fault", sig(2), 1'h1);
    chk("oc_delay", n >= 5, 1'h1);
    overcurrent = 1'h0;
    wt(2, 1'h0, 4);
    chk("oc_clear", sig(2), 1'h0);
    overtemp = 1'h1;
    wt(2, 1'h1, 2);
    chk("ot_fault", sig(2), 1'h1);
    cyc(1);
    chk("ot_off", power_switch_on, 1'h0);
    overtemp = 1'h0;
    cyc(10);
    chk("ot_hyst", power_switch_on, 1'h0);
    overtemp_cooled = 1'h1;
    wt(3, 1'h1, 4);
    chk("ot_on", power_switch_on, 1'h1);
    chk("ot_hold", sig(2), 1'h1);
    wt(2, 1'h0, 16);
    chk("ot_clear", sig(2), 1'h0);
    overtemp_cooled = 1'h0;
    auto_off = 1'h1;
    overcurrent = 1'h1;
    wt(2, 1'h1, 16);
    cyc(4);
    chk("host_off", {sig(2), power_switch_on}, 8'h00);
    overcurrent = 1'h0;
    auto_off = 1'h0;
    $display("done fault");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {arst_n, en_req, auto_off, attach_enable, attach_sensed, load_present} = 6'h00;
    {chg_current_above, cdp_handshake_done, bc12_load_present} = 3'h0;
    {overcurrent, overtemp, overtemp_cooled} = 3'h0;
    mode_select_pins = 3'h0;
    err_count = 0;
    checks = 0;
    cyc(10);
    chk("rst_out", {power_switch_on, discharge_on, chg_attach_n_oe, fault_n_oe}, 8'h00);
    arst_n = 1'h1;
    cyc(2);
    chk("od_data", {chg_attach_n_o, fault_n_o}, 8'h00);
    t_enables;
    t_modes;
    t_dcp;
    t_charge;
    t_attach;
    t_safety;
    t_nolimit;
    en_req = 1'h1;
    cyc(30);
    t_fault;
    summarize;
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #40000;
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
